/* rtl/pwtfd_pkg.sv */
package pwtfd_pkg;

   // sizes of the timer block
   localparam int NUM_TIMERS = 2;
   localparam int CNT_W      = 8;
   localparam int PSC_W      = 3;
   localparam int PSC_STAGES = 7;

   // system clock rate
   localparam int SYS_CLK_HZ = 10_000_000;

   // counter values
   localparam logic [CNT_W-1:0] CNT_FULL   = 8'hFF;
   localparam logic [CNT_W-1:0] CNT_ONE    = 8'h01;
   localparam logic [CNT_W-1:0] CNT_RESET  = 8'h00;
   localparam logic [CNT_W-1:0] PRE_RESET  = 8'h00;
   localparam logic [CNT_W-1:0] CTRL_RESET = 8'h00;

   // prescaler masks: full seven-stage chain and the fixed divide by four of timer 1
   localparam logic [PSC_STAGES-1:0] PSC_ALL_MASK = 7'h7F;
   localparam logic [PSC_STAGES-1:0] PSC_STEP     = 7'h01;
   localparam logic [PSC_STAGES-1:0] PSC_RESET    = 7'h00;
   localparam logic [PSC_STAGES-1:0] T1_DIV_MASK  = 7'h03;

   // timer index of each divider source
   localparam int TIMER0 = 0;
   localparam int TIMER1 = 1;

   // two-bit mode field encodings
   typedef enum logic [1:0] {
      MODE_STOP  = 2'h0,
      MODE_EVENT = 2'h1,
      MODE_TIMER = 2'h2,
      MODE_PULSE = 2'h3
   } pwtfd_mode_type;

   // control register layout: mode 7:6, spare 5, run 4, edge 3, prescale 2:0
   typedef struct packed {
      pwtfd_mode_type   timer_mode_field;
      logic             spare;
      logic             timer_run_bit;
      logic             timer_edge_select;
      logic [PSC_W-1:0] timer_prescale_field;
   } pwtfd_ctrl_type;

   // pulse measurement progress
   typedef enum logic {
      MEAS_WAIT,
      MEAS_COUNT
   } pwtfd_meas_type;

   // software access strobes for one timer
   typedef struct packed {
      logic             ctrl_wr;
      logic             preload_wr;
      logic             count_rd;
      logic             flag_wr;
      logic             flag_wdata;
      logic [CNT_W-1:0] wdata;
   } pwtfd_sw_type;

   // frequency divider and shared pin configuration
   typedef struct packed {
      logic pfd_enable;
      logic pfd_source_sel;
      logic pa1_dir_input;
      logic pa1_data_bit;
   } pwtfd_pfd_type;

endpackage : pwtfd_pkg

/* rtl/pwtfd_prescale.sv */
`timescale 1ns/1ns
`default_nettype none

module pwtfd_prescale
   import pwtfd_pkg::*;
(
   input  wire logic             clock_i,
   input  wire logic             resetn_i,
   input  wire logic [PSC_W-1:0] psc_i,
   output logic                  tick0_o,
   output logic                  tick1_o
);

   logic [PSC_STAGES-1:0] cnt_r;
   logic [PSC_STAGES-1:0] mask;

   // free running divider chain
   always_ff @(posedge clock_i or negedge resetn_i) begin
      if (!resetn_i) begin
         cnt_r <= PSC_RESET;
      end else begin
         cnt_r <= cnt_r + PSC_STEP;
      end
   end

   // timer 0 ratio two to the power of the prescale field, timer 1 fixed divide by four
   assign mask    = ~(PSC_ALL_MASK << psc_i);
   assign tick0_o = ((cnt_r & mask) == mask);
   assign tick1_o = ((cnt_r & T1_DIV_MASK) == T1_DIV_MASK);

endmodule : pwtfd_prescale

`default_nettype wire

/* rtl/pwtfd_top.sv */
`timescale 1ns/1ns
`default_nettype none

module pwtfd_top
   import pwtfd_pkg::*;
(
   input  wire logic                                clock_i,
   input  wire logic                                resetn_i,
   input  wire pwtfd_sw_type   [NUM_TIMERS-1:0]     sw_i,
   input  wire logic           [NUM_TIMERS-1:0]     irq_enable_i,
   input  wire logic                                power_down_i,
   input  wire logic           [NUM_TIMERS-1:0]     timer_pin_i,
   input  wire logic           [NUM_TIMERS-1:0]     timer_pin_dir_i,
   input  wire logic           [NUM_TIMERS-1:0]     pullup_opt_i,
   input  wire pwtfd_pfd_type                       pfd_i,
   output logic                [NUM_TIMERS-1:0][CNT_W-1:0] count_o,
   output logic                [NUM_TIMERS-1:0][CNT_W-1:0] read_data_o,
   output pwtfd_ctrl_type      [NUM_TIMERS-1:0]     ctrl_o,
   output logic                [NUM_TIMERS-1:0]     irq_flag_o,
   output logic                [NUM_TIMERS-1:0]     irq_o,
   output logic                [NUM_TIMERS-1:0]     overflow_o,
   output logic                                     wakeup_o,
   output logic                                     pfd_level_o,
   output logic                                     pa1_o,
   output logic                                     pa1_oe_o,
   output logic                [NUM_TIMERS-1:0]     pullup_en_o
);

   logic [NUM_TIMERS-1:0] tick;
   logic [NUM_TIMERS-1:0] ovf;
   logic [NUM_TIMERS-1:0] flag_r;
   logic                  pfd_r;
   logic                  pfd_src;
   logic                  wakeup_r;
   logic                  pa1_r;
   logic                  pa1_oe_r;
   logic [NUM_TIMERS-1:0] pullup_r;

   // internal timer clock enables
   pwtfd_prescale u_prescale (
      .clock_i  (clock_i),
      .resetn_i (resetn_i),
      .psc_i    (ctrl_o[TIMER0].timer_prescale_field),
      .tick0_o  (tick[TIMER0]),
      .tick1_o  (tick[TIMER1])
   );

   for (genvar g = 0; g < NUM_TIMERS; g++) begin : g_timer

      pwtfd_ctrl_type   ctrl_r;
      pwtfd_ctrl_type   ctrl_nxt;
      pwtfd_meas_type   meas_r;
      logic [CNT_W-1:0] count_r;
      logic [CNT_W-1:0] preload_r;
      logic [CNT_W-1:0] rdata_r;
      logic             pin_prev_r;
      logic             pin_samp_r;
      logic             pin_ok;
      logic             active_lvl;
      logic             pin_active;
      logic             samp_active;
      logic             evt_edge;
      logic             pulse_mode;
      logic             start;
      logic             stop;
      logic             inhibit;
      logic             inc;
      logic             hw_clear;

      // the pin only serves the timer while its direction bit says input
      assign pin_ok      = timer_pin_dir_i[g];
      assign pulse_mode  = (ctrl_r.timer_mode_field == MODE_PULSE);
      assign active_lvl  = ctrl_r.timer_edge_select;
      assign pin_active  = (timer_pin_i[g] == active_lvl);
      assign samp_active = (pin_samp_r == active_lvl);

      // event mode edge: low select counts rising, high select counts falling
      assign evt_edge = pin_ok & (ctrl_r.timer_edge_select ?
                                  (pin_prev_r & ~timer_pin_i[g]) :
                                  (~pin_prev_r & timer_pin_i[g]));

      // pulse starts on entry to the active level and ends on leaving it
      assign start = pin_ok & tick[g] & (meas_r == MEAS_WAIT) & ~samp_active & pin_active;
      assign stop  = pin_ok & tick[g] & (meas_r == MEAS_COUNT) & ~pin_active;

      // counting clock is held while software touches the counter
      assign inhibit = sw_i[g].count_rd | sw_i[g].preload_wr;

      always_comb begin
         inc = 1'b0;
         if (ctrl_r.timer_run_bit && !inhibit) begin
            unique case (ctrl_r.timer_mode_field)
               MODE_STOP:  inc = 1'b0;
               MODE_EVENT: inc = evt_edge;
               MODE_TIMER: inc = tick[g];
               MODE_PULSE: inc = tick[g] & pin_active & pin_ok &
                                 ((meas_r == MEAS_COUNT) | start);
            endcase
         end
      end

      assign ovf[g]   = inc & (count_r == CNT_FULL);
      assign hw_clear = pulse_mode & ctrl_r.timer_run_bit & stop;

      // last pin level for event edges
      always_ff @(posedge clock_i or negedge resetn_i) begin
         if (!resetn_i) begin
            pin_prev_r <= 1'b0;
         end else begin
            pin_prev_r <= timer_pin_i[g];
         end
      end

      // pin level seen only at the internal timer clock
      always_ff @(posedge clock_i or negedge resetn_i) begin
         if (!resetn_i) begin
            pin_samp_r <= 1'b0;
         end else if (tick[g]) begin
            pin_samp_r <= timer_pin_i[g];
         end
      end

      // measurement progress, dropped whenever the run bit is low
      always_ff @(posedge clock_i or negedge resetn_i) begin
         if (!resetn_i) begin
            meas_r <= MEAS_WAIT;
         end else if (!ctrl_r.timer_run_bit || !pulse_mode) begin
            meas_r <= MEAS_WAIT;
         end else if (start) begin
            meas_r <= MEAS_COUNT;
         end else if (stop) begin
            meas_r <= MEAS_WAIT;
         end
      end

      // control register, software write wins over the automatic clear
      always_comb begin
         ctrl_nxt = ctrl_r;
         if (sw_i[g].ctrl_wr) begin
            ctrl_nxt = pwtfd_ctrl_type'(sw_i[g].wdata);
         end else if (hw_clear) begin
            ctrl_nxt.timer_run_bit = 1'b0;
         end
      end

      always_ff @(posedge clock_i or negedge resetn_i) begin
         if (!resetn_i) begin
            ctrl_r <= pwtfd_ctrl_type'(CTRL_RESET);
         end else begin
            ctrl_r <= ctrl_nxt;
         end
      end

      // preload register
      always_ff @(posedge clock_i or negedge resetn_i) begin
         if (!resetn_i) begin
            preload_r <= PRE_RESET;
         end else if (sw_i[g].preload_wr) begin
            preload_r <= sw_i[g].wdata;
         end
      end

      // counter
      always_ff @(posedge clock_i or negedge resetn_i) begin
         if (!resetn_i) begin
            count_r <= CNT_RESET;
         end else if (sw_i[g].preload_wr && !ctrl_r.timer_run_bit) begin
            count_r <= sw_i[g].wdata;
         end else if (ovf[g]) begin
            count_r <= preload_r;
         end else if (inc) begin
            count_r <= count_r + CNT_ONE;
         end
      end

      // value captured by a software read
      always_ff @(posedge clock_i or negedge resetn_i) begin
         if (!resetn_i) begin
            rdata_r <= CNT_RESET;
         end else if (sw_i[g].count_rd) begin
            rdata_r <= count_r;
         end
      end

      // request flag: overflow set wins over software write
      always_ff @(posedge clock_i or negedge resetn_i) begin
         if (!resetn_i) begin
            flag_r[g] <= 1'b0;
         end else if (ovf[g]) begin
            flag_r[g] <= 1'b1;
         end else if (sw_i[g].flag_wr) begin
            flag_r[g] <= sw_i[g].flag_wdata;
         end
      end

      assign count_o[g]     = count_r;
      assign read_data_o[g] = rdata_r;
      assign ctrl_o[g]      = ctrl_r;
      assign irq_o[g]       = flag_r[g] & irq_enable_i[g];
   end

   assign irq_flag_o = flag_r;
   assign overflow_o = ovf;

   // wake-up in power-down on an overflow whose flag was still low
   always_ff @(posedge clock_i or negedge resetn_i) begin
      if (!resetn_i) begin
         wakeup_r <= 1'b0;
      end else begin
         wakeup_r <= power_down_i & |(ovf & ~flag_r);
      end
   end

   // divider level toggles on each overflow of the chosen timer
   assign pfd_src = pfd_i.pfd_source_sel ? ovf[TIMER1] : ovf[TIMER0];

   always_ff @(posedge clock_i or negedge resetn_i) begin
      if (!resetn_i) begin
         pfd_r <= 1'b0;
      end else if (!pfd_i.pfd_enable) begin
         pfd_r <= 1'b0;
      end else if (pfd_src) begin
         pfd_r <= ~pfd_r;
      end
   end

   // shared pin: divider gated by data bit, plain port when divider off
   always_ff @(posedge clock_i or negedge resetn_i) begin
      if (!resetn_i) begin
         pa1_r    <= 1'b0;
         pa1_oe_r <= 1'b0;
      end else begin
         pa1_oe_r <= ~pfd_i.pa1_dir_input;
         if (pfd_i.pfd_enable) begin
            pa1_r <= pfd_i.pa1_data_bit & pfd_r;
         end else begin
            pa1_r <= pfd_i.pa1_data_bit;
         end
      end
   end

   // pull-high option follows the configuration in every mode
   always_ff @(posedge clock_i or negedge resetn_i) begin
      if (!resetn_i) begin
         pullup_r <= '0;
      end else begin
         pullup_r <= pullup_opt_i;
      end
   end

   assign wakeup_o    = wakeup_r;
   assign pfd_level_o = pfd_r;
   assign pa1_o       = pa1_r;
   assign pa1_oe_o    = pa1_oe_r;
   assign pullup_en_o = pullup_r;

endmodule : pwtfd_top

`default_nettype wire

/* verification/pwtfd_sva.sv */
`timescale 1ns/1ns
`default_nettype none

module pwtfd_sva
   import pwtfd_pkg::*;
(
   input wire logic                               clock_i,
   input wire logic                               resetn_i,
   input wire pwtfd_sw_type   [NUM_TIMERS-1:0]    sw_i,
   input wire logic           [NUM_TIMERS-1:0]    irq_enable_i,
   input wire logic                               power_down_i,
   input wire logic           [NUM_TIMERS-1:0]    timer_pin_i,
   input wire logic           [NUM_TIMERS-1:0]    timer_pin_dir_i,
   input wire logic           [NUM_TIMERS-1:0]    pullup_opt_i,
   input wire pwtfd_pfd_type                      pfd_i,
   input wire logic [NUM_TIMERS-1:0][CNT_W-1:0]   count_o,
   input wire logic [NUM_TIMERS-1:0][CNT_W-1:0]   read_data_o,
   input wire pwtfd_ctrl_type [NUM_TIMERS-1:0]    ctrl_o,
   input wire logic           [NUM_TIMERS-1:0]    irq_flag_o,
   input wire logic           [NUM_TIMERS-1:0]    irq_o,
   input wire logic           [NUM_TIMERS-1:0]    overflow_o,
   input wire logic                               wakeup_o,
   input wire logic                               pfd_level_o,
   input wire logic                               pa1_o,
   input wire logic                               pa1_oe_o,
   input wire logic           [NUM_TIMERS-1:0]    pullup_en_o
);
   default clocking cb @(posedge clock_i); endclocking
   default disable iff (!resetn_i);

   irq_gate_a: assert property (irq_o == (irq_flag_o & irq_enable_i))
      else $error("irq output differs from flag and enable");
   flag_set_a: assert property (overflow_o[1] |=> irq_flag_o[1])
      else $error("overflow did not set request flag");
   ovf_full_a: assert property (overflow_o[1] |-> count_o[1] == CNT_FULL)
      else $error("overflow away from all ones");
   pfd_toggle_a: assert property (overflow_o[1] && pfd_i.pfd_enable && pfd_i.pfd_source_sel
      |=> pfd_level_o != $past(pfd_level_o))
      else $error("divider did not toggle on overflow");
   pfd_off_a: assert property (!pfd_i.pfd_enable |=> !pfd_level_o)
      else $error("divider level high while disabled");
   pin_dir_a: assert property (1'b1 |=> pa1_oe_o == !$past(pfd_i.pa1_dir_input))
      else $error("pin enable does not follow direction");
   pin_gate_a: assert property (!pfd_i.pa1_data_bit |=> !pa1_o)
      else $error("pin high with data bit low");
   rd_hold_a: assert property (sw_i[0].count_rd && !sw_i[0].preload_wr
      |=> count_o[0] == $past(count_o[0]))
      else $error("counter advanced during read");
   rd_data_a: assert property (sw_i[1].count_rd |=> read_data_o[1] == $past(count_o[1]))
      else $error("read data differs from counter");
   auto_clear_a: assert property ($fell(ctrl_o[1].timer_run_bit) && !$past(sw_i[1].ctrl_wr)
      |-> $past(ctrl_o[1].timer_mode_field) == MODE_PULSE)
      else $error("run cleared by hardware outside pulse mode");
   power_wake_a: assert property (overflow_o[1] && power_down_i && !irq_flag_o[1] |=> wakeup_o)
      else $error("no wake-up on overflow in power-down");
   pull_high_a: assert property (1'b1 |=> pullup_en_o == $past(pullup_opt_i))
      else $error("pull-high enable lost");

   cover property (overflow_o[1]);
   cover property (wakeup_o);
   cover property ($fell(ctrl_o[1].timer_run_bit));
endmodule : pwtfd_sva

bind pwtfd_top pwtfd_sva i_pwtfd_sva (.clock_i, .resetn_i, .sw_i, .irq_enable_i,
   .power_down_i, .timer_pin_i, .timer_pin_dir_i, .pullup_opt_i, .pfd_i, .count_o,
   .read_data_o, .ctrl_o, .irq_flag_o, .irq_o, .overflow_o, .wakeup_o, .pfd_level_o,
   .pa1_o, .pa1_oe_o, .pullup_en_o);

`default_nettype wire

/* verification/pwtfd_pulse_src.sv */
`timescale 1ns/1ns
`default_nettype none

module pwtfd_pulse_src (
   input  wire logic       clock_i,
   input  wire logic       go_i,
   input  wire logic       level_i,
   input  wire logic [7:0] width_i,
   output logic            pin_o,
   output logic            busy_o
);
   logic [7:0] left_r = 8'h00;

   // one pulse of width_i clocks per go, level_i while active
   always_ff @(posedge clock_i) begin
      if (go_i && left_r == 8'h00)
         left_r <= width_i;
      else if (left_r != 8'h00)
         left_r <= left_r - 8'h01;
   end

   assign busy_o = (left_r != 8'h00);
   assign pin_o  = busy_o ? level_i : ~level_i;
endmodule : pwtfd_pulse_src

`default_nettype wire

/* verification/pwtfd_top_tb.sv */
`timescale 1ns/1ns
`default_nettype none

module pwtfd_top_tb;
   import pwtfd_pkg::*;

   logic clock_i = 1'b0;
   logic resetn_i = 1'b0;
   pwtfd_sw_type [1:0] sw_r = '0;
   logic [1:0] irq_en_r = 2'b00;
   logic pd_r = 1'b0;
   logic [1:0] pull_r = 2'b01;
   logic [1:0] dir_r = 2'b11;
   pwtfd_pfd_type pfd_r = 4'hD;
   logic go_r = 1'b0;
   logic lvl_r = 1'b0;
   logic [7:0] wid_r = 8'h08;
   logic src_pin, busy;
   logic [1:0][7:0] count_o, read_data_o;
   pwtfd_ctrl_type [1:0] ctrl_o;
   logic [1:0] irq_flag_o, irq_o, overflow_o, pullup_en_o;
   logic wakeup_o, pfd_level_o, pa1_o, pa1_oe_o;
   int err_count = 0;
   int compares = 0;
   int cyc = 0;
   int wake_cnt = 0;
   logic [3:0] pcfg [4] = '{4'hC, 4'hE, 4'h1, 4'h3};
   logic [1:0] pexp [4] = '{2'h2, 2'h0, 2'h3, 2'h1};

   always #50 clock_i = ~clock_i;

   pwtfd_top i_pwtfd_top (.clock_i(clock_i), .resetn_i(resetn_i), .sw_i(sw_r),
      .irq_enable_i(irq_en_r), .power_down_i(pd_r), .timer_pin_i({src_pin, 1'b1}),
      .timer_pin_dir_i(dir_r), .pullup_opt_i(pull_r), .pfd_i(pfd_r), .count_o(count_o),
      .read_data_o(read_data_o), .ctrl_o(ctrl_o), .irq_flag_o(irq_flag_o), .irq_o(irq_o),
      .overflow_o(overflow_o), .wakeup_o(wakeup_o), .pfd_level_o(pfd_level_o),
      .pa1_o(pa1_o), .pa1_oe_o(pa1_oe_o), .pullup_en_o(pullup_en_o));

   pwtfd_pulse_src i_pwtfd_pulse_src (.clock_i(clock_i), .go_i(go_r), .level_i(lvl_r),
      .width_i(wid_r), .pin_o(src_pin), .busy_o(busy));

   task automatic test_done();
      $display("compares %0d errors %0d", compares, err_count);
      if (err_count == 0 && compares > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask : test_done

   always @(posedge clock_i) begin
      cyc++;
      if (wakeup_o === 1'b1)
         wake_cnt++;
      if (cyc == 20000) begin
         err_count++;
         test_done();
      end
   end

   task automatic chk(input string nm, input logic [7:0] exp, input logic [7:0] got);
      compares++;
      if (got !== exp) begin
         err_count++;
         $display("ERROR %s expected %h seen %h", nm, exp, got);
      end
   endtask : chk

   task automatic inr(input string nm, input logic [7:0] v, input logic [7:0] lo,
                      input logic [7:0] hi);
      chk(nm, 8'h01, {7'h00, (v >= lo && v <= hi)});
   endtask : inr

   task automatic step(input int n);
      repeat (n) @(posedge clock_i);
      #1;
   endtask : step

   task automatic sw(input int g, input logic [12:0] v);
      @(posedge clock_i);
      sw_r[g] <= v;
      @(posedge clock_i);
      sw_r[g] <= '0;
      #1;
   endtask : sw

   task automatic wr_ctrl(input int g, input logic [7:0] d);
      sw(g, {5'b10000, d});
   endtask : wr_ctrl

   task automatic wr_pre(input int g, input logic [7:0] d);
      sw(g, {5'b01000, d});
   endtask : wr_pre

   task automatic wr_flag(input logic b);
      sw(1, {4'b0001, b, 8'h00});
   endtask : wr_flag

   task automatic wait_ovf();
      int n;
      n = 0;
      while (overflow_o[1] !== 1'b1 && n < 1100) begin
         step(1);
         n++;
      end
      if (n == 1100)
         chk("overflow", 8'h01, 8'h00);
   endtask : wait_ovf

   task automatic pulse(input logic [7:0] w);
      @(posedge clock_i);
      wid_r <= w;
      go_r <= 1'b1;
      @(posedge clock_i);
      go_r <= 1'b0;
      step(1);
      for (int i = 0; i < 300 && busy; i++)
         step(1);
      step(8);
   endtask : pulse

   initial begin
      repeat (4) @(posedge clock_i);
      resetn_i <= 1'b1;
      step(1);
      chk("ctrl1", 8'h00, ctrl_o[1]);
      chk("pullup", 8'h01, {6'h00, pullup_en_o});
      wr_pre(1, 8'hFE);
      chk("preload stopped", 8'hFE, count_o[1]);
      sw(1, {5'b00100, 8'h00});
      chk("read", 8'hFE, read_data_o[1]);
      wr_ctrl(1, 8'h90);
      wait_ovf();
      chk("full", 8'hFF, count_o[1]);
      step(1);
      chk("reload", 8'hFE, count_o[1]);
      chk("flag", 8'h02, {6'h00, irq_flag_o});
      chk("irq masked", 8'h00, {6'h00, irq_o});
      chk("pfd", 8'h01, {7'h00, pfd_level_o});
      @(posedge clock_i);
      irq_en_r <= 2'b10;
      #1;
      chk("irq", 8'h02, {6'h00, irq_o});
      chk("pa1", 8'h03, {6'h00, pa1_oe_o, pa1_o});
      wr_flag(1'b0);
      @(posedge clock_i);
      pd_r <= 1'b1;
      wr_pre(1, 8'h10);
      chk("preload running", 8'h00, {7'h00, count_o[1] == 8'h10});
      wait_ovf();
      step(2);
      chk("next reload", 8'h10, count_o[1]);
      chk("wake", 8'h01, wake_cnt[7:0]);
      chk("run held", 8'h90, ctrl_o[1]);
      wr_ctrl(1, 8'h80);
      wr_flag(1'b1);
      wr_pre(1, 8'hFD);
      wr_ctrl(1, 8'h90);
      wait_ovf();
      step(3);
      chk("no wake", 8'h01, wake_cnt[7:0]);
      wr_ctrl(1, 8'h00);
      wr_flag(1'b0);
      @(posedge clock_i);
      pd_r <= 1'b0;
      for (int p = 0; p < 8; p++) begin
         wr_pre(0, 8'h00);
         wr_ctrl(0, 8'h90 | p[7:0]);
         step(8 << p);
         wr_ctrl(0, 8'h80);
         inr("prescale", count_o[0], 8'h07, 8'h0A);
      end
      // timer 0 counting every clock, software touches block one count each
      wr_pre(0, 8'h00);
      wr_ctrl(0, 8'h90);
      sw(0, {5'b00100, 8'h00});
      chk("read inhibit", 8'h01, count_o[0]);
      chk("read running", 8'h01, read_data_o[0]);
      wr_pre(0, 8'h40);
      chk("preload inhibit", 8'h02, count_o[0]);
      wr_ctrl(0, 8'h80);
      wr_pre(1, 8'h00);
      wr_ctrl(1, 8'hD0);
      pulse(8'd40);
      inr("width low", count_o[1], 8'h09, 8'h0B);
      chk("auto clear", 8'hC0, ctrl_o[1]);
      pulse(8'd80);
      inr("single shot", count_o[1], 8'h09, 8'h0B);
      @(posedge clock_i);
      lvl_r <= 1'b1;
      wr_pre(1, 8'h00);
      wr_ctrl(1, 8'hD8);
      pulse(8'd40);
      inr("width high", count_o[1], 8'h09, 8'h0B);
      chk("auto clear high", 8'hC8, ctrl_o[1]);
      wr_pre(1, 8'hFC);
      wr_ctrl(1, 8'hD8);
      pulse(8'd40);
      inr("pulse ovf", count_o[1], 8'hFD, 8'hFF);
      chk("pulse flag", 8'h02, {6'h00, irq_flag_o});
      wr_pre(1, 8'h00);
      wr_ctrl(1, 8'h50);
      repeat (3) pulse(8'd3);
      chk("events", 8'h03, count_o[1]);
      chk("event run", 8'h50, ctrl_o[1]);
      @(posedge clock_i);
      dir_r <= 2'b01;
      pulse(8'd3);
      chk("pin as output", 8'h03, count_o[1]);
      @(posedge clock_i);
      dir_r <= 2'b11;
      for (int i = 0; i < 4; i++) begin
         @(posedge clock_i);
         pfd_r <= pcfg[i];
         step(2);
         chk("pin cfg", {6'h00, pexp[i]}, {6'h00, pa1_oe_o, pa1_o});
      end
      test_done();
   end
endmodule : pwtfd_top_tb

`default_nettype wire
